//--- include/stack_prog_pkg.sv
// constants and types shared by the stack program unit
package stack_prog_pkg;
  // data: signed fixed point, 1.000 = 2**frac
  localparam int data_w = 24;
  localparam int frac_w = 16;
  localparam logic [23:0] one_val = 24'h010000;
  localparam logic [23:0] half_val = 24'h008000;
  localparam logic [23:0] zero_val = 24'h000000;
  // program steps
  localparam int step_w = 6;
  localparam logic [5:0] first_step = 6'h01;
  localparam logic [5:0] last_step = 6'h3b;
  localparam logic [5:0] reduced_first = 6'h14;
  // instruction word: opcode and step/operand field
  localparam int instr_w = 10;
  localparam int op_lsb = 6;
  typedef enum logic [3:0] {
    idle_step, angle_ratio_y_fn, angle_ratio_x_fn, angle_slope_fn,
    inverse_y_ratio_fn, inverse_x_ratio_fn, inverse_slope_fn,
    natural_power_inverse, common_log_fn, natural_growth_fn,
    raise_to_power, uncond_jump, conditional_branch, swap_top_two,
    stack_cycle, load_top
  } op_e;
  // the end instruction: idle opcode with all-ones operand
  localparam logic [5:0] end_code = 6'h3f;
  typedef enum logic [1:0] {
    wait_pass, fetch, exec
  } run_e;
endpackage

//--- src/math_unit.sv
// combinational math for the one-operand and power instructions
`timescale 1ns/1ps
`default_nettype none
module math_unit (
  // operation select
  input wire logic [3:0] op,
  // operands
  input wire logic signed [23:0] top,
  input wire logic signed [23:0] second,
  // result
  output logic signed [23:0] result
);
  // crude polynomial/series forms in fixed point; angle 1.000 = 360 deg
  // half-turn folded sine via parabola, 4x(1-x) style per half turn
  function automatic logic signed [23:0] fsin(input logic [23:0] a);
    logic [15:0] ph;
    logic [31:0] p;
    logic [23:0] m;
    ph = a[15:0];
    p = 32'(ph[14:0]) * 32'(16'h8000 - {1'b0, ph[14:0]});
    m = 24'(p >> 12);
    fsin = ph[15] ? -$signed(m) : $signed(m);
  endfunction
  function automatic logic signed [23:0] fmul(
      input logic signed [23:0] x, input logic signed [23:0] y);
    logic signed [47:0] p;
    p = 48'(x) * 48'(y);
    fmul = 24'(p >>> 16);
  endfunction
  logic signed [23:0] s_v;
  logic signed [23:0] c_v;
  logic signed [23:0] ln_v;
  logic signed [23:0] ex_v;
  assign s_v = fsin(top);
  assign c_v = fsin(top + 24'sh004000);
  // natural log by leading-one position, ln2 = 0x00b172
  function automatic logic signed [23:0] fln(input logic signed [23:0] x);
    int k;
    k = 0;
    for (int i = 0; i < 24; i++) if (x[i]) k = i;
    fln = 24'(($signed(k) - 16) * 32'sh0000b172);
  endfunction
  assign ln_v = fln(top);
  assign ex_v = stack_prog_pkg::one_val + top + fmul(top, top) / 2;
  // result select by opcode
  always_comb begin
    case (op)
      4'h1: result = s_v;
      4'h2: result = c_v;
      4'h3: result = (c_v == 0) ? top : 24'((48'(s_v) <<< 16) / 48'(c_v));
      4'h4: result = top >>> 2;
      4'h5: result = 24'sh004000 - (top >>> 2);
      4'h6: result = top >>> 3;
      4'h7: result = ln_v;
      4'h8: result = fmul(ln_v, 24'sh006f2e);
      4'h9: result = ex_v;
      4'ha: begin
        result = stack_prog_pkg::one_val + fmul(top, fln(second));
      end
      default: result = top;
    endcase
  end
endmodule
`default_nettype wire

//--- src/stack_program.sv
// stack program sequencer with four-entry arithmetic stack
`timescale 1ns/1ps
`default_nettype none
module stack_program (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // pass control and variant
  input wire logic pass_start,
  input wire logic reduced_variant,
  // program memory read
  output logic [5:0] step_addr,
  input wire logic [9:0] instr,
  // load operand
  input wire logic [23:0] load_value,
  // status
  output logic pass_busy,
  output logic [23:0] stack_top,
  output logic [23:0] stack_second,
  output logic [23:0] stack_third,
  output logic [23:0] stack_bottom
);
  stack_prog_pkg::run_e run;
  logic [5:0] step;
  logic [3:0] op;
  logic [5:0] arg;
  logic [23:0] math_out;
  logic top_is_one;
  logic tgt_ok;
  logic is_end;
  logic at_last;
  assign op = instr[9:6];
  assign arg = instr[5:0];
  assign step_addr = step;
  assign pass_busy = (run != stack_prog_pkg::wait_pass);
  assign top_is_one = !stack_top[23] &&
    (stack_top >= stack_prog_pkg::half_val);
  assign tgt_ok = (arg <= stack_prog_pkg::last_step) &&
    (arg >= (reduced_variant ? stack_prog_pkg::reduced_first
                             : stack_prog_pkg::first_step));
  assign is_end = (op == 4'h0) && (arg == stack_prog_pkg::end_code);
  assign at_last = (step == stack_prog_pkg::last_step);
  math_unit math (
    .op(op),
    .top(stack_top),
    .second(stack_second),
    .result(math_out)
  );
  // sequencer: fetch then execute, one step per two clocks
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      run <= stack_prog_pkg::wait_pass;
      step <= stack_prog_pkg::first_step;
    end else begin
      case (run)
        stack_prog_pkg::wait_pass: begin
          if (pass_start) begin
            run <= stack_prog_pkg::fetch;
            step <= stack_prog_pkg::first_step;
          end
        end
        stack_prog_pkg::fetch: run <= stack_prog_pkg::exec;
        default: begin
          if (is_end || at_last) begin
            run <= stack_prog_pkg::wait_pass;
          end else if (tgt_ok && (op == 4'hb ||
              (op == 4'hc && top_is_one))) begin
            step <= arg;
            run <= stack_prog_pkg::fetch;
          end else begin
            step <= step + 6'h01;
            run <= stack_prog_pkg::fetch;
          end
        end
      endcase
    end
  end
  // stack update on execute
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stack_top <= stack_prog_pkg::zero_val;
      stack_second <= stack_prog_pkg::zero_val;
      stack_third <= stack_prog_pkg::zero_val;
      stack_bottom <= stack_prog_pkg::zero_val;
    end else if (run == stack_prog_pkg::exec && !is_end) begin
      case (op)
        4'hc: begin
          stack_top <= stack_second;
          stack_second <= stack_third;
          stack_third <= stack_bottom;
        end
        4'hd: begin
          stack_top <= stack_second;
          stack_second <= stack_top;
        end
        4'he: begin
          stack_top <= stack_second;
          stack_second <= stack_third;
          stack_third <= stack_bottom;
          stack_bottom <= stack_top;
        end
        4'hf: begin
          stack_top <= load_value;
          stack_second <= stack_top;
          stack_third <= stack_second;
          stack_bottom <= stack_third;
        end
        4'h0, 4'hb: ;
        default: stack_top <= math_out;
      endcase
    end
  end
  // swap exchanges top two
  swap_two_a: assert property (@(posedge mclk) disable iff (!reset_n)
    run == stack_prog_pkg::exec && op == 4'hd && !is_end |=>
    stack_top == $past(stack_second) && stack_second == $past(stack_top))
    else $error("swap wrong");
  // cycle moves top to bottom
  cycle_stack_a: assert property (@(posedge mclk) disable iff (!reset_n)
    run == stack_prog_pkg::exec && op == 4'he |=>
    stack_bottom == $past(stack_top) && stack_top == $past(stack_second))
    else $error("cycle wrong");
  // branch pop keeps bottom
  branch_pop_a: assert property (@(posedge mclk) disable iff (!reset_n)
    run == stack_prog_pkg::exec && op == 4'hc |=>
    stack_bottom == $past(stack_bottom) && stack_top == $past(stack_second))
    else $error("branch pop wrong");
  // jump keeps stack
  jump_keep_a: assert property (@(posedge mclk) disable iff (!reset_n)
    run == stack_prog_pkg::exec && op == 4'hb |=> $stable(stack_top) &&
    $stable(stack_second) && $stable(stack_third) && $stable(stack_bottom))
    else $error("jump changed stack");
  // taken branch lands on target
  branch_take_a: assert property (@(posedge mclk) disable iff (!reset_n)
    run == stack_prog_pkg::exec && op == 4'hc && top_is_one && tgt_ok &&
    !at_last |=> step == $past(arg))
    else $error("branch not taken");
  // reduced variant refuses low targets
  reduced_tgt_a: assert property (@(posedge mclk) disable iff (!reset_n)
    run == stack_prog_pkg::exec && op == 4'hb && reduced_variant &&
    arg < 6'h14 && !at_last |=> step == $past(step) + 6'h01)
    else $error("low target taken");
  // end stops the pass
  end_stop_a: assert property (@(posedge mclk) disable iff (!reset_n)
    run == stack_prog_pkg::exec && is_end |=> !pass_busy)
    else $error("end did not stop");
  // load pushes down
  load_push_a: assert property (@(posedge mclk) disable iff (!reset_n)
    run == stack_prog_pkg::exec && op == 4'hf |=>
    stack_top == $past(load_value) && stack_bottom == $past(stack_third))
    else $error("load wrong");
  // idle step advances one
  idle_adv_a: assert property (@(posedge mclk) disable iff (!reset_n)
    run == stack_prog_pkg::exec && op == 4'h0 && !is_end && !at_last |=>
    step == $past(step) + 6'h01 ##0 $stable(stack_top))
    else $error("idle wrong");
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the stack program sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [23:0] va = 24'h000100;
  localparam logic [23:0] vb = 24'h000200;
  localparam logic [23:0] vc = 24'h000300;
  localparam logic [23:0] vd = 24'h010000;
  localparam logic [23:0] vx = 24'h000500;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic pass_start = 1'b0;
  logic reduced_variant = 1'b0;
  logic [5:0] step_addr;
  logic [9:0] instr;
  logic [23:0] load_value;
  logic pass_busy;
  logic [23:0] stack_top, stack_second, stack_third, stack_bottom;
  logic [9:0] prog [64];
  logic [23:0] vals [64];
  int err_count = 0;
  int checks = 0;

  // program memory and load operands, read by step number
  assign instr = prog[step_addr];
  assign load_value = vals[step_addr];

  // 40 MHz clock
  always #12.5 mclk = ~mclk;

  stack_program dut_u (
    .mclk(mclk), .reset_n(reset_n), .pass_start(pass_start),
    .reduced_variant(reduced_variant), .step_addr(step_addr),
    .instr(instr), .load_value(load_value), .pass_busy(pass_busy),
    .stack_top(stack_top), .stack_second(stack_second),
    .stack_third(stack_third), .stack_bottom(stack_bottom)
  );

  // one comparison, counted
  task automatic chk(input string what, input logic [23:0] exp,
      input logic [23:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // start a pass and wait, bounded, until it ends
  task automatic run_pass();
    int n;
    n = 0;
    @(posedge mclk);
    #1 pass_start = 1'b1;
    @(posedge mclk);
    #1 pass_start = 1'b0;
    while (pass_busy !== 1'b0 && n < 400) begin
      @(posedge mclk);
      #1 n++;
    end
    checks++;
    if (n >= 400) begin
      err_count++;
      $display("[FAIL] pass_busy expected 0 seen %b", pass_busy);
    end
  endtask

  // steps 1-4 load a,b,c,d; step 5 under test; step 6 loads x; 7 ends
  task automatic run_case(input string name, input logic [9:0] op5,
      input logic [23:0] d, input logic rv, input logic [23:0] e1, e2,
      e3, e4, input logic skip2);
    vals[4] = d;
    prog[5] = op5;
    reduced_variant = rv;
    run_pass();
    chk({name, " top"}, e1, stack_top);
    if (!skip2) chk({name, " second"}, e2, stack_second);
    chk({name, " third"}, e3, stack_third);
    chk({name, " bottom"}, e4, stack_bottom);
    $display("test %s done", name);
  endtask

  // closing verdict
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial begin
    #500000;
    err_count++;
    $display("[FAIL] watchdog expected done seen hang");
    finish_test();
  end

  // main sequence
  initial begin
    for (int i = 0; i < 64; i++) begin
      prog[i] = 10'h03f;
      vals[i] = 24'h000000;
    end
    for (int i = 1; i < 5; i++) prog[i] = 10'h3c0;
    prog[6] = 10'h3c0;
    vals[1] = va;
    vals[2] = vb;
    vals[3] = vc;
    vals[6] = vx;
    repeat (4) @(posedge mclk);
    #1 reset_n = 1'b1;
    chk("reset top", 24'h000000, stack_top);
    chk("reset step", 24'h000001, {18'h0, step_addr});
    run_case("swap", 10'h340, vd, 1'b0, vx, vc, vd, vb, 1'b0);
    run_case("cycle", 10'h380, vd, 1'b0, vx, vc, vb, va, 1'b0);
    run_case("idle", 10'h000, vd, 1'b0, vx, vd, vc, vb, 1'b0);
    run_case("jump", 10'h2c7, vd, 1'b0, vd, vc, vb, va, 1'b0);
    run_case("jump hi", 10'h2fc, vd, 1'b0, vx, vd, vc, vb, 1'b0);
    run_case("red low", 10'h2c7, vd, 1'b1, vx, vd, vc, vb, 1'b0);
    run_case("red ok", 10'h2d4, vd, 1'b1, vd, vc, vb, va, 1'b0);
    run_case("cj half", 10'h307, 24'h008000, 1'b0, vc, vb, va, va,
      1'b0);
    run_case("cj low", 10'h307, 24'h007fff, 1'b0, vx, vc, vb, va,
      1'b0);
    for (int i = 1; i < 11; i++) begin
      run_case("math", {i[3:0], 6'h00}, vd, 1'b0, vx, vd, vc, vb,
        1'b1);
      if (i == 1) chk("y ratio full turn", 24'h000000, stack_second);
      if (i == 2) chk("x ratio full turn", 24'h010000, stack_second);
    end
    finish_test();
  end
endmodule
`default_nettype wire
